// *** inc/hvcfg_pkg.sv ***
/*
 Shared constants, field layouts and helpers for the harvester register
 bank: register offsets, reset values, voltage scales and packed carriers.
 Assumes millivolt-coded rail readings and a single 125 MHz clock.
*/
package hvcfg_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_FLAGS = 8'h02;
	localparam logic [7:0] ADDR_MASK = 8'h03;
	localparam logic [7:0] ADDR_SYSCFG = 8'h04;
	localparam logic [7:0] ADDR_WAKE_CONFIG = 8'h05;

	// bus address of the device; value is arbitrary
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

	// ------------------------------------------------------------
	// reset values and writable bits
	// ------------------------------------------------------------
	localparam logic [4:0] FLAGS_RST = 5'h00;
	localparam logic [4:0] MASK_RST = 5'h00;
	localparam logic [7:0] SYSCFG_RST = 8'h07;
	localparam logic [7:0] WAKE_CONFIG_RST = 8'h87;
	localparam logic [7:0] WAKE_CONFIG_WMASK = 8'hD7;

	// ------------------------------------------------------------
	// voltage scales, millivolts
	// ------------------------------------------------------------
	localparam int MV_W = 13;
	localparam logic [12:0] REG_BASE_MV = 13'h0FA0;
	localparam logic [12:0] REG_STEP_MV = 13'h0032;
	localparam logic [12:0] WAKE_BASE_MV = 13'h0BB8;
	localparam logic [12:0] WAKE_STEP_MV = 13'h0064;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int POR_MEAS_US = 1000;
	localparam int POR_MEAS_CYCLES = POR_MEAS_US * CLK_MHZ;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic harvest_ready;
		logic opencircuit_ready;
		logic opencircuit_valid;
		logic enable_state;
		logic wake_state;
	} hvcfg_status_t;

	typedef struct packed {
		logic regulation_mode_select;
		logic [2:0] recharge_threshold;
		logic [3:0] regulation_voltage;
	} hvcfg_syscfg_t;

	typedef struct packed {
		logic periodic_opencircuit_enable;
		logic periodic_thermal_enable;
		logic rsvd5;
		logic irq_pin_repurpose;
		logic rsvd3;
		logic [2:0] wake_threshold;
	} hvcfg_wake_config_t;

	// ------------------------------------------------------------
	// scale helpers
	// ------------------------------------------------------------
	function automatic logic [12:0] reg_target_mv(input logic [3:0] code);
		reg_target_mv = REG_BASE_MV + 13'(REG_STEP_MV * {9'h000, code});
	endfunction

	function automatic logic [12:0] wake_mv(input logic [2:0] code);
		wake_mv = WAKE_BASE_MV + 13'(WAKE_STEP_MV * {10'h000, code});
	endfunction

	function automatic logic [12:0] recharge_mv(input logic [2:0] code);
		case (code)
			3'h0: recharge_mv = 13'h0019;
			3'h1: recharge_mv = 13'h0032;
			3'h2: recharge_mv = 13'h004B;
			3'h3: recharge_mv = 13'h0064;
			3'h4: recharge_mv = 13'h0096;
			3'h5: recharge_mv = 13'h00C8;
			3'h6: recharge_mv = 13'h00FA;
			default: recharge_mv = 13'h012C;
		endcase
	endfunction

endpackage

// *** src/hvcfg_sync.sv ***
/*
 Three-stage input synchroniser with agreement filter for pin inputs.
 Assumes inputs are asynchronous to ref_clk_i; output moves only when
 the second and third stages agree.
*/
`timescale 1ns/1ns
module hvcfg_sync #(
	parameter int W = 2,
	parameter logic [1:0] RST_VAL = 2'h3
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1, s2, s3;
	logic [W-1:0] next_q;

	if (W != 2) begin : g_chk
		$error("hvcfg_sync: width must match reset value width");
	end

	// ----------------------------------------------------------------
	// filter: first stage feeds only the second
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q_o;
		for (int i = 0; i < W; i++) begin
			if (s2[i] == s3[i]) begin
				next_q[i] = s3[i];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= next_q;
		end
	end
endmodule

// *** src/hvcfg_ctrl.sv ***
/*
 Rail regulation, wake comparison and measurement trigger logic driven
 by the configuration registers. Assumes sys_mv_i and the tick/request
 strobes are produced on ref_clk_i by neighbouring logic.
*/
`timescale 1ns/1ns
module hvcfg_ctrl
	import hvcfg_pkg::*;
#(
	parameter int POR_CYCLES = POR_MEAS_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire hvcfg_syscfg_t syscfg_i,
	input wire hvcfg_wake_config_t wake_config_i,
	input wire logic [12:0] sys_mv_i,
	input wire logic period_tick_i,
	input wire logic meas_request_i,
	input wire logic thermal_monitor_enable_i,
	output logic boost_run_o,
	output logic [12:0] target_mv_o,
	output logic wake_o,
	output logic wake_state_o,
	output logic oc_start_o,
	output logic th_start_o
);
	logic por_pend;
	logic [31:0] por_cnt;
	logic next_boost, next_wake, next_pend, next_oc, next_th;
	logic [31:0] next_cnt;
	logic [12:0] next_target, hyst, wthr;

	if (POR_CYCLES < 1) begin : g_chk
		$error("hvcfg_ctrl: POR_CYCLES must be at least 1");
	end

	// ----------------------------------------------------------------
	// next-state computation
	// ----------------------------------------------------------------
	always_comb begin
		next_target = reg_target_mv(syscfg_i.regulation_voltage);
		hyst = recharge_mv(syscfg_i.recharge_threshold);
		wthr = wake_mv(wake_config_i.wake_threshold);
		next_boost = boost_run_o;
		if (!syscfg_i.regulation_mode_select) begin
			next_boost = 1'b1;
		end else if (boost_run_o && sys_mv_i >= next_target) begin
			next_boost = 1'b0;
		end else if (!boost_run_o &&
			({1'b0, sys_mv_i} + {1'b0, hyst}) <= {1'b0, next_target}) begin
			next_boost = 1'b1;
		end
		next_wake = (sys_mv_i >= wthr);
		// initial measurement waits so software may still cancel it
		next_pend = por_pend;
		next_cnt = por_cnt;
		if (por_pend) begin
			if (!wake_config_i.periodic_opencircuit_enable) begin
				next_pend = 1'b0;
			end else if (por_cnt == 32'h0000_0000) begin
				next_pend = 1'b0;
			end else begin
				next_cnt = por_cnt - 32'h0000_0001;
			end
		end
		next_oc = meas_request_i ||
			(wake_config_i.periodic_opencircuit_enable &&
			(period_tick_i || (por_pend && por_cnt == 32'h0000_0000)));
		next_th = thermal_monitor_enable_i &&
			wake_config_i.periodic_thermal_enable && period_tick_i;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boost_run_o <= 1'b1;
			target_mv_o <= REG_BASE_MV;
			wake_o <= 1'b0;
			wake_state_o <= 1'b1;
			por_pend <= 1'b1;
			por_cnt <= 32'(POR_CYCLES - 1);
			oc_start_o <= 1'b0;
			th_start_o <= 1'b0;
		end else begin
			boost_run_o <= next_boost;
			target_mv_o <= next_target;
			wake_o <= next_wake;
			wake_state_o <= !next_wake;
			por_pend <= next_pend;
			por_cnt <= next_cnt;
			oc_start_o <= next_oc;
			th_start_o <= next_th;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_cont_regulate:
	assert property (!syscfg_i.regulation_mode_select |=> boost_run_o)
		else $error("boost not running in regulation mode");
	a_hyst_stop:
	assert property (syscfg_i.regulation_mode_select && boost_run_o &&
		sys_mv_i >= target_mv_o && $stable(syscfg_i) |=> !boost_run_o)
		else $error("boost did not stop at target");
	a_hyst_restart:
	assert property (syscfg_i == 8'hF0 && !boost_run_o &&
		sys_mv_i == 13'h0E74 |=> boost_run_o)
		else $error("boost did not restart 300 mV below 4.0 V");
	a_target_scale:
	assert property (syscfg_i.regulation_voltage == 4'hF |=>
		target_mv_o == 13'h128E)
		else $error("code 15 target is not 4750 mV");
	a_wake_level:
	assert property (wake_config_i.wake_threshold == 3'h0 &&
		sys_mv_i < 13'h0BB8 |=> wake_state_o && !wake_o)
		else $error("wake state wrong below 3.0 V");
	a_oc_gate:
	assert property (!wake_config_i.periodic_opencircuit_enable &&
		!meas_request_i |=> !oc_start_o)
		else $error("open-circuit start without enable or request");
	a_therm_gate:
	assert property (!thermal_monitor_enable_i ||
		!wake_config_i.periodic_thermal_enable |=> !th_start_o)
		else $error("thermal start while not enabled");
endmodule

// *** src/hvcfg_top.sv ***
/*
 Register bank of the harvester: two-wire serial slave, interrupt flags
 with mask, system regulation and wake configuration, interrupt pin mux.
 Assumes status inputs and rail readings are on ref_clk_i; scl/sda come
 from pins and are synchronised here.
*/
`timescale 1ns/1ns
module hvcfg_top
	import hvcfg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
	parameter int POR_CYCLES = POR_MEAS_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic harvest_ready_i,
	input wire logic opencircuit_ready_i,
	input wire logic opencircuit_valid_i,
	input wire logic enable_state_i,
	input wire logic [12:0] sys_mv_i,
	input wire logic period_tick_i,
	input wire logic meas_request_i,
	input wire logic thermal_monitor_enable_i,
	input wire logic source_discharge_i,
	output logic irq_pin_o,
	output logic irq_pin_oe_o,
	output logic boost_run_o,
	output logic [12:0] target_mv_o,
	output logic wake_o,
	output logic wake_state_o,
	output logic oc_meas_start_o,
	output logic thermal_meas_start_o
);
	typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_RACK} hvcfg_st_t;

	logic [1:0] rst_sync;
	logic rst_n;
	logic scl_f, sda_f, scl_q, sda_q;
	logic start_c, stop_c, rise_c, fall_c;
	hvcfg_st_t st, next_st;
	logic [3:0] cnt, next_cnt;
	logic [7:0] sh, next_sh, ptr, next_ptr;
	logic first, next_first, rd_mode, next_rd_mode;
	logic next_sda_oe, rd_clr;
	logic [4:0] flags, next_flags, mask, next_mask, chg;
	hvcfg_status_t status_c, status_prev;
	hvcfg_syscfg_t syscfg, next_syscfg;
	hvcfg_wake_config_t wake_config, next_wake_config;
	logic next_irq_o, next_irq_oe;

	if (POR_CYCLES < 1) begin : g_chk
		$error("hvcfg_top: POR_CYCLES must be at least 1");
	end

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	// release through two stages so no flop sees a runt release edge
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	hvcfg_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.d_i({scl_i, sda_i}),
		.q_o({scl_f, sda_f})
	);

	// bus conditions from filtered levels
	assign start_c = scl_f && scl_q && sda_q && !sda_f;
	assign stop_c = scl_f && scl_q && !sda_q && sda_f;
	assign rise_c = scl_f && !scl_q;
	assign fall_c = !scl_f && scl_q;

	// ----------------------------------------------------------------
	// rail, wake and measurement control
	// ----------------------------------------------------------------
	hvcfg_ctrl #(.POR_CYCLES(POR_CYCLES)) u_ctrl (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.syscfg_i(syscfg),
		.wake_config_i(wake_config),
		.sys_mv_i(sys_mv_i),
		.period_tick_i(period_tick_i),
		.meas_request_i(meas_request_i),
		.thermal_monitor_enable_i(thermal_monitor_enable_i),
		.boost_run_o(boost_run_o),
		.target_mv_o(target_mv_o),
		.wake_o(wake_o),
		.wake_state_o(wake_state_o),
		.oc_start_o(oc_meas_start_o),
		.th_start_o(thermal_meas_start_o)
	);

	assign status_c = '{harvest_ready_i, opencircuit_ready_i,
		opencircuit_valid_i, enable_state_i, wake_state_o};
	assign chg = status_c ^ status_prev;

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_byte(input logic [7:0] a,
		input logic [4:0] f, input logic [4:0] m,
		input logic [7:0] s, input logic [7:0] w);
		case (a)
			ADDR_FLAGS: read_byte = {3'h0, f};
			ADDR_MASK: read_byte = {3'h0, m};
			ADDR_SYSCFG: read_byte = s;
			ADDR_WAKE_CONFIG: read_byte = w;
			default: read_byte = 8'h00; // unmapped reads as zero
		endcase
	endfunction

	// ----------------------------------------------------------------
	// serial slave, register file and interrupt pin: next values
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_sh = sh;
		next_ptr = ptr;
		next_first = first;
		next_rd_mode = rd_mode;
		next_sda_oe = sda_oe_o;
		next_mask = mask;
		next_syscfg = syscfg;
		next_wake_config = wake_config;
		rd_clr = 1'b0;
		case (st)
			ST_IDLE: begin
				next_sda_oe = 1'b0;
			end
			ST_ADDR: begin
				if (rise_c) begin
					next_sh = {sh[6:0], sda_f};
					next_cnt = cnt + 4'h1;
				end else if (fall_c && cnt == 4'h8) begin
					if (sh[7:1] == DEV_ADDR) begin
						next_st = ST_ACK;
						next_sda_oe = 1'b1;
						next_rd_mode = sh[0];
					end else begin
						next_st = ST_IDLE;
					end
				end
			end
			ST_WR: begin
				if (rise_c) begin
					next_sh = {sh[6:0], sda_f};
					next_cnt = cnt + 4'h1;
				end else if (fall_c && cnt == 4'h8) begin
					if (first) begin
						next_ptr = sh;
						next_first = 1'b0;
					end else begin
						// flag register is read-only, writes dropped
						case (ptr)
							ADDR_MASK: next_mask = sh[4:0];
							ADDR_SYSCFG: next_syscfg = sh;
							ADDR_WAKE_CONFIG: next_wake_config = sh & WAKE_CONFIG_WMASK;
							default: next_mask = mask;
						endcase
						next_ptr = ptr + 8'h01;
					end
					next_st = ST_ACK;
					next_sda_oe = 1'b1;
				end
			end
			ST_RD: begin
				if (rise_c) begin
					next_cnt = cnt + 4'h1;
				end else if (fall_c) begin
					if (cnt == 4'h8) begin
						next_sda_oe = 1'b0;
						next_st = ST_RACK;
					end else begin
						next_sh = {sh[6:0], 1'b0};
						next_sda_oe = !sh[6];
					end
				end
			end
			ST_ACK, ST_RACK: begin
				// host nack ends a read burst
				if (st == ST_RACK && rise_c && sda_f) begin
					next_st = ST_IDLE;
				end else if (fall_c) begin
					next_cnt = 4'h0;
					if (rd_mode) begin
						next_sh = read_byte(ptr, flags, mask, syscfg, wake_config);
						next_sda_oe = !next_sh[7];
						next_ptr = ptr + 8'h01;
						rd_clr = (ptr == ADDR_FLAGS);
						next_st = ST_RD;
					end else begin
						next_sda_oe = 1'b0;
						next_st = ST_WR;
					end
				end
			end
			default: begin
				next_st = ST_IDLE;
			end
		endcase
		if (start_c) begin
			next_st = ST_ADDR;
			next_cnt = 4'h0;
			next_first = 1'b1;
			next_sda_oe = 1'b0;
		end else if (stop_c) begin
			next_st = ST_IDLE;
			next_sda_oe = 1'b0;
		end
		// a toggle in the clearing cycle survives the clear
		next_flags = (flags & ~{5{rd_clr}}) | chg;
		if (wake_config.irq_pin_repurpose) begin
			next_irq_oe = 1'b1;
			next_irq_o = source_discharge_i;
		end else begin
			next_irq_oe = |(flags & ~mask);
			next_irq_o = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			st <= ST_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			ptr <= 8'h00;
			first <= 1'b1;
			rd_mode <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
			flags <= FLAGS_RST;
			mask <= MASK_RST;
			syscfg <= SYSCFG_RST;
			wake_config <= WAKE_CONFIG_RST;
			status_prev <= '0;
			irq_pin_o <= 1'b0;
			irq_pin_oe_o <= 1'b0;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
			st <= next_st;
			cnt <= next_cnt;
			sh <= next_sh;
			ptr <= next_ptr;
			first <= next_first;
			rd_mode <= next_rd_mode;
			sda_o <= 1'b0;
			sda_oe_o <= next_sda_oe;
			flags <= next_flags;
			mask <= next_mask;
			syscfg <= next_syscfg;
			wake_config <= next_wake_config;
			status_prev <= status_c;
			irq_pin_o <= next_irq_o;
			irq_pin_oe_o <= next_irq_oe;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n);

	a_flag_set:
	assert property (chg != 5'h00 |=> (flags & $past(chg)) == $past(chg))
		else $error("status toggle did not set its flag");
	a_read_clear:
	assert property (rd_clr && chg == 5'h00 |=> flags == 5'h00)
		else $error("flag read did not clear flags");
	a_irq_assert:
	assert property (!wake_config.irq_pin_repurpose && (flags & ~mask) != 5'h00
		|=> irq_pin_oe_o && !irq_pin_o)
		else $error("unmasked flag not driving pin low");
	a_irq_masked:
	assert property (!wake_config.irq_pin_repurpose && (flags & ~mask) == 5'h00
		|=> !irq_pin_oe_o)
		else $error("pin driven with no unmasked flag");
	a_pin_pushpull:
	assert property (wake_config.irq_pin_repurpose |=> irq_pin_oe_o &&
		irq_pin_o == $past(source_discharge_i))
		else $error("discharge output not following control");
endmodule

// *** verif/hvcfg_host.sv ***
/*
 Behavioural two-wire serial host for the harvester register bank.
 Assumes an external pull-up: the wire is high unless someone pulls low.
*/
`timescale 1ns/1ns
module hvcfg_host
	import hvcfg_pkg::*;
(
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	// ------------------------------------------------------------
	// bus idle: both lines released, clock stands high
	// ------------------------------------------------------------
	initial begin
		scl_o = 1'h1;
		sda_low_o = 1'h0;
	end

	// one scl phase; longer than the pin filter needs
	task automatic ph();
		repeat (10) @(posedge clk_i);
	endtask

	// data moves only while scl is low, sampled at end of high
	task automatic bit_io(input logic b, output logic s);
		ph();
		sda_low_o <= ~b;
		ph();
		scl_o <= 1'h1;
		ph();
		s = sda_i;
		scl_o <= 1'h0;
	endtask

	task automatic start();
		ph();
		sda_low_o <= 1'h0;
		ph();
		scl_o <= 1'h1;
		ph();
		sda_low_o <= 1'h1;
		ph();
		scl_o <= 1'h0;
	endtask

	task automatic stop();
		ph();
		sda_low_o <= 1'h1;
		ph();
		scl_o <= 1'h1;
		ph();
		sda_low_o <= 1'h0;
		ph();
	endtask

	// byte out, msb first; ack is the ninth bit pulled low
	task automatic tx(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'h1, s);
		ack = ~s;
	endtask

	task automatic rx(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
		bit_io(last, s);
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] v,
			output logic ok);
		logic a, b, c;
		start();
		tx({DEV_ADDR_DEFAULT, 1'h0}, a);
		tx(p, b);
		tx(v, c);
		stop();
		ok = a & b & c;
	endtask

	// pointer write, repeated start, one byte read with nack
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic a;
		start();
		tx({DEV_ADDR_DEFAULT, 1'h0}, a);
		tx(p, a);
		start();
		tx({DEV_ADDR_DEFAULT, 1'h1}, a);
		rx(1'h1, d);
		stop();
	endtask
endmodule

// *** verif/tb.sv ***
/*
 Self-checking bench for the harvester register bank.
 Assumes the host model in hvcfg_host.sv and a pulled-up data wire.
*/
`timescale 1ns/1ns
module tb
	import hvcfg_pkg::*;
;
	// short post-reset delay keeps the run brief
	localparam int POR_N = 3000;
	logic clk, rst_n, scl, sda_low, sda_o, sda_oe, tick, req, te, dis;
	logic irq_o, irq_oe, boost, wake, wake_st, oc, th;
	logic [3:0] st;
	logic [12:0] sys, target;
	int n_fail, n_tests, n_oc, n_th;
	wire logic sda_w = sda_low ? 1'h0 : (sda_oe ? sda_o : 1'h1);

	hvcfg_top #(.POR_CYCLES(POR_N)) DUT (
		.ref_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_o(sda_oe), .harvest_ready_i(st[3]),
		.opencircuit_ready_i(st[2]), .opencircuit_valid_i(st[1]),
		.enable_state_i(st[0]), .sys_mv_i(sys), .period_tick_i(tick),
		.meas_request_i(req), .thermal_monitor_enable_i(te),
		.source_discharge_i(dis), .irq_pin_o(irq_o),
		.irq_pin_oe_o(irq_oe), .boost_run_o(boost), .target_mv_o(target),
		.wake_o(wake), .wake_state_o(wake_st), .oc_meas_start_o(oc),
		.thermal_meas_start_o(th));

	hvcfg_host host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
		.sda_low_o(sda_low));

	// ------------------------------------------------------------
	// clock, pulse counters, shared tasks
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	// pulses are counted so no check depends on the exact cycle
	always @(posedge clk) begin
		if (oc === 1'h1) n_oc++;
		if (th === 1'h1) n_th++;
	end

	task automatic chk(input string nm, input logic [12:0] e,
			input logic [12:0] s);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] v);
		logic a;
		host.wr(p, v, a);
		chk("ack", 1'h1, a);
	endtask

	task automatic rdc(input string nm, input logic [7:0] p,
			input logic [7:0] e);
		logic [7:0] d;
		host.rd(p, d);
		chk(nm, e, d);
	endtask

	task automatic pulse(input logic t, input logic r);
		@(posedge clk) begin
			tick <= t;
			req <= r;
		end
		@(posedge clk) begin
			tick <= 1'h0;
			req <= 1'h0;
		end
		cyc(3);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] d;
		cyc(POR_N + 100);
		chk("por_meas", 13'h0001, 13'(n_oc));
		chk("target", 13'h10FE, target);
		chk("boost", 1'h1, boost);
		host.rd(ADDR_FLAGS, d);
		rdc("flags", ADDR_FLAGS, 8'h00);
		rdc("mask", ADDR_MASK, 8'h00);
		rdc("syscfg", ADDR_SYSCFG, 8'h07);
		rdc("wake_config", ADDR_WAKE_CONFIG, 8'h87);
		rdc("unmapped", 8'h20, 8'h00);
		$display("test reset done");
	endtask

	// both edges of each of the four status inputs, pin follows the flag
	task automatic t_flags();
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 4; i++) begin
				@(posedge clk) st[i] <= ~st[i];
				cyc(4);
				chk("irq_oe", 1'h1, irq_oe);
				chk("irq_low", 1'h0, irq_o);
				rdc("flags", ADDR_FLAGS, 8'(2 << i));
				cyc(4);
				chk("irq_rel", 1'h0, irq_oe);
			end
		end
		rdc("flags_clr", ADDR_FLAGS, 8'h00);
		// flag register ignores writes
		wr(ADDR_FLAGS, 8'h1F);
		rdc("flags_ro", ADDR_FLAGS, 8'h00);
		$display("test flags done");
	endtask

	task automatic t_mask();
		wr(ADDR_MASK, 8'hFF);
		rdc("mask", ADDR_MASK, 8'h1F);
		@(posedge clk) st[1] <= ~st[1];
		cyc(4);
		chk("masked", 1'h0, irq_oe);
		rdc("flags", ADDR_FLAGS, 8'h04);
		wr(ADDR_MASK, 8'h00);
		$display("test mask done");
	endtask

	// battery mode: 4250 target, 50 mV hysteresis
	task automatic t_sys();
		wr(ADDR_SYSCFG, 8'h95);
		cyc(3);
		chk("target", 13'h109A, target);
		@(posedge clk) sys <= 13'h109A;
		cyc(3);
		chk("boost_off", 1'h0, boost);
		@(posedge clk) sys <= 13'h1069;
		cyc(3);
		chk("boost_hold", 1'h0, boost);
		@(posedge clk) sys <= 13'h1068;
		cyc(3);
		chk("boost_on", 1'h1, boost);
		// widest hysteresis at the lowest target: restart at 3700 mV
		wr(ADDR_SYSCFG, 8'hF0);
		cyc(3);
		chk("boost_off7", 1'h0, boost);
		@(posedge clk) sys <= 13'h0E75;
		cyc(3);
		chk("boost_hold7", 1'h0, boost);
		@(posedge clk) sys <= 13'h0E74;
		cyc(3);
		chk("boost_on7", 1'h1, boost);
		@(posedge clk) sys <= 13'h10CC;
		wr(ADDR_SYSCFG, 8'h00);
		cyc(3);
		chk("target_min", 13'h0FA0, target);
		chk("boost_mode0", 1'h1, boost);
		$display("test sys done");
	endtask

	task automatic t_wake();
		wr(ADDR_WAKE_CONFIG, 8'h80);
		@(posedge clk) sys <= 13'h0BB8;
		cyc(3);
		chk("wake", 1'h1, wake);
		chk("wake_st", 1'h0, wake_st);
		@(posedge clk) sys <= 13'h0BB7;
		cyc(3);
		chk("wake_lo", 1'h0, wake);
		chk("wake_st_lo", 1'h1, wake_st);
		rdc("flags", ADDR_FLAGS, 8'h01);
		wr(ADDR_WAKE_CONFIG, 8'h87);
		@(posedge clk) sys <= 13'h0E73;
		cyc(3);
		chk("wake_top_lo", 1'h0, wake);
		@(posedge clk) sys <= 13'h0E74;
		cyc(3);
		chk("wake_top", 1'h1, wake);
		@(posedge clk) sys <= 13'h10CC;
		rdc("flags2", ADDR_FLAGS, 8'h01);
		$display("test wake done");
	endtask

	task automatic t_meas();
		int o, h;
		o = n_oc;
		pulse(1'h1, 1'h0);
		chk("oc_tick", 13'(o + 1), 13'(n_oc));
		wr(ADDR_WAKE_CONFIG, 8'h47);
		pulse(1'h1, 1'h0);
		chk("oc_off", 13'(o + 1), 13'(n_oc));
		chk("th_no_en", 13'h0000, 13'(n_th));
		@(posedge clk) te <= 1'h1;
		pulse(1'h1, 1'h0);
		chk("th_tick", 13'h0001, 13'(n_th));
		pulse(1'h0, 1'h1);
		chk("oc_req", 13'(o + 2), 13'(n_oc));
		wr(ADDR_WAKE_CONFIG, 8'h87);
		$display("test meas done");
	endtask

	task automatic t_repurp();
		wr(ADDR_WAKE_CONFIG, 8'h97);
		@(posedge clk) dis <= 1'h1;
		cyc(3);
		chk("pp_oe", 1'h1, irq_oe);
		chk("pp_hi", 1'h1, irq_o);
		@(posedge clk) begin
			dis <= 1'h0;
			st[3] <= ~st[3];
		end
		cyc(4);
		chk("pp_lo", 1'h0, irq_o);
		chk("pp_oe2", 1'h1, irq_oe);
		wr(ADDR_WAKE_CONFIG, 8'h87);
		cyc(3);
		chk("od_back", 1'h1, irq_oe);
		chk("od_low", 1'h0, irq_o);
		rdc("flags", ADDR_FLAGS, 8'h10);
		$display("test repurpose done");
	endtask

	// second reset, post-reset measurement cancelled in time
	task automatic t_por();
		int o;
		@(posedge clk) rst_n <= 1'h0;
		cyc(6);
		@(posedge clk) rst_n <= 1'h1;
		cyc(6);
		o = n_oc;
		wr(ADDR_WAKE_CONFIG, 8'h07);
		cyc(POR_N);
		chk("por_cancel", 13'(o), 13'(n_oc));
		$display("test por done");
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'h0;
		st = 4'h0;
		sys = 13'h10CC;
		tick = 1'h0;
		req = 1'h0;
		te = 1'h0;
		dis = 1'h0;
		n_fail = 0;
		n_tests = 0;
		n_oc = 0;
		n_th = 0;
		cyc(6);
		@(posedge clk) rst_n <= 1'h1;
		cyc(6);
		t_reset();
		t_flags();
		t_mask();
		t_sys();
		t_wake();
		t_meas();
		t_repurp();
		t_por();
		conclude();
	end

	// about twice the expected run
	initial begin
		#800000;
		n_fail++;
		conclude();
	end
endmodule
